// ==== logic/secure_write_tamper_control.sv ====
// Secure user zone write gating, reset delay and tamper shutdown
`timescale 1ns/1ps

// Functional notes
// - The internal write cycle runs from the stop that ends a write until the timed cycle after programming ends.
// - After power-up or tamper reset the device stays inoperable for a delay once conditions are normal.
// - The reset sequence returns all security flags to their initial values.
// - Supply voltage and clock frequency monitors raise tamper when out of limits.
// - A light sensor input also raises tamper.
// - While tamper is detected nothing operates and no command is answered.
// - A user zone write in authentication or encryption mode is buffered until the checksum arrives.
// - A matching checksum lets the buffered data be programmed.
// - A wrong checksum drops the buffer and resets the crypto engine.
// - Other traffic between write and checksum aborts the write and leaves the zone unchanged.
module secure_write_tamper_control
#(
	parameter logic [swt_pkg::TIMER_W-1:0] WRITE_CYCLE_CYC =
		swt_pkg::WRITE_CYCLE_LD,                   // Write cycle length
	parameter logic [swt_pkg::TIMER_W-1:0] POR_DELAY_CYC =
		swt_pkg::POR_DELAY_LD                      // Reset delay length
)
(
	input  wire logic                        clk,          // 200 MHz clock
	input  wire logic                        nrst,         // Async reset, low
	input  wire logic                        vccFault,     // Supply out of range
	input  wire logic                        clkFault,     // Clock out of range
	input  wire logic                        lightFault,   // Light on die
	input  wire logic                        addrByte,     // Device address seen
	input  wire logic                        wrCmd,        // User write header
	input  wire logic [swt_pkg::ADDR_W-1:0] wrAddr,       // Write start address
	input  wire logic                        wrByte,       // Write data strobe
	input  wire logic [swt_pkg::DATA_W-1:0] wrData,       // Write data byte
	input  wire logic                        stopCond,     // Valid stop seen
	input  wire logic                        sumCmd,       // Checksum received
	input  wire logic [swt_pkg::SUM_W-1:0]  sumWord,      // Host checksum
	input  wire logic [swt_pkg::SUM_W-1:0]  expSum,       // Engine checksum
	input  wire logic                        otherTraffic, // Unrelated command
	input  wire logic [swt_pkg::FLAG_W-1:0] flagSet,      // Flag set pulses
	output logic                             addrAck,      // Address acked
	output logic                             writeBusy,    // Write cycle active
	output logic                             memWrEn,      // Array write strobe
	output logic [swt_pkg::ADDR_W-1:0]      memAddr,      // Array address
	output logic [swt_pkg::DATA_W-1:0]      memData,      // Array data
	output logic                             cryptoReset,  // Engine reset pulse
	output logic                             writeDropped, // Write discarded
	output logic [swt_pkg::FLAG_W-1:0]      secFlags,     // Security flags
	output logic                             tamperFlag,   // Tamper present
	output logic                             deviceReady   // Device operable
);

	swt_pkg::swt_state_type state_reg;
	swt_pkg::swt_state_type state_next;

	logic                           tamperNow;
	logic                           armed_reg;
	logic                           timerLoad;
	logic [swt_pkg::TIMER_W-1:0]   timerVal;
	logic                           timerDone;
	logic                           sumMatch;
	logic                           progDone;
	logic                           cryptoMode;
	logic                           cryptoWr_reg;
	logic [swt_pkg::ADDR_W-1:0]    baseAddr_reg;
	logic [swt_pkg::BUF_CNT_W-1:0] bufCount_reg;
	logic [swt_pkg::BUF_CNT_W-1:0] rdCount_reg;
	logic                           rdPend_reg;
	logic [swt_pkg::BUF_IDX_W-1:0] pendIdx_reg;
	logic                           bufWrite;
	logic                           bufRead;

	logic                           addrAck_reg;
	logic                           writeBusy_reg;
	logic                           memWrEn_reg;
	logic [swt_pkg::ADDR_W-1:0]    memAddr_reg;
	logic [swt_pkg::DATA_W-1:0]    memData_reg;
	logic                           cryptoReset_reg;
	logic                           writeDropped_reg;
	logic [swt_pkg::FLAG_W-1:0]    secFlags_reg;
	logic                           tamperFlag_reg;
	logic                           deviceReady_reg;

	swt_buf_if bufBus();

	// States in which the device answers the bus
	function automatic logic acceptsBus(swt_pkg::swt_state_type st);
		acceptsBus = (st == swt_pkg::ST_IDLE) ||
			(st == swt_pkg::ST_COLLECT) ||
			(st == swt_pkg::ST_AWAIT_SUM) ||
			(st == swt_pkg::ST_AWAIT_STOP);
	endfunction

	// Page roll-over address for a buffered byte
	function automatic logic [swt_pkg::ADDR_W-1:0] pageAddr(
		logic [swt_pkg::ADDR_W-1:0]    base,
		logic [swt_pkg::BUF_IDX_W-1:0] idx);
		logic [swt_pkg::BUF_IDX_W-1:0] low;
		low = base[swt_pkg::BUF_IDX_W-1:0] + idx;
		pageAddr = {base[swt_pkg::ADDR_W-1:swt_pkg::BUF_IDX_W], low};
	endfunction

	assign tamperNow = vccFault || clkFault || lightFault;

	assign cryptoMode = secFlags_reg[swt_pkg::FLAG_AUTH] ||
		secFlags_reg[swt_pkg::FLAG_ENC];
	assign sumMatch = (sumWord == expSum);
	assign progDone = (rdCount_reg == bufCount_reg) && !rdPend_reg;

	// Sequencer next state; tamper overrides every state
	always_comb
	begin
		state_next = state_reg;
		timerLoad = 1'b0;
		timerVal = POR_DELAY_CYC;
		if (tamperNow)
		begin
			state_next = swt_pkg::ST_TAMPER;
		end
		else
		begin
			case (state_reg)
				swt_pkg::ST_TAMPER:
				begin
					state_next = swt_pkg::ST_RESET_WAIT;
				end
				swt_pkg::ST_RESET_WAIT:
				begin
					if (!armed_reg)
					begin
						timerLoad = 1'b1;
					end
					else if (timerDone)
					begin
						state_next = swt_pkg::ST_IDLE;
					end
				end
				swt_pkg::ST_IDLE:
				begin
					if (wrCmd)
					begin
						state_next = swt_pkg::ST_COLLECT;
					end
				end
				swt_pkg::ST_COLLECT:
				begin
					if (stopCond && (bufCount_reg == 5'h00))
					begin
						state_next = swt_pkg::ST_IDLE;
					end
					else if (stopCond && cryptoWr_reg)
					begin
						state_next = swt_pkg::ST_AWAIT_SUM;
					end
					else if (stopCond)
					begin
						state_next = swt_pkg::ST_PROGRAM;
					end
				end
				swt_pkg::ST_AWAIT_SUM:
				begin
					if (otherTraffic)
					begin
						state_next = swt_pkg::ST_IDLE;
					end
					else if (sumCmd && sumMatch)
					begin
						state_next = swt_pkg::ST_AWAIT_STOP;
					end
					else if (sumCmd)
					begin
						state_next = swt_pkg::ST_IDLE;
					end
				end
				swt_pkg::ST_AWAIT_STOP:
				begin
					if (otherTraffic)
					begin
						state_next = swt_pkg::ST_IDLE;
					end
					else if (stopCond)
					begin
						state_next = swt_pkg::ST_PROGRAM;
					end
				end
				swt_pkg::ST_PROGRAM:
				begin
					if (progDone)
					begin
						state_next = swt_pkg::ST_WRITE_CYCLE;
						timerLoad = 1'b1;
						timerVal = WRITE_CYCLE_CYC;
					end
				end
				// Busy until the write cycle ends
				swt_pkg::ST_WRITE_CYCLE:
				begin
					if (timerDone)
					begin
						state_next = swt_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state_next = swt_pkg::ST_TAMPER;
				end
			endcase
		end
	end

	// State register; reset enters the delay sequence
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= swt_pkg::ST_RESET_WAIT;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Timer is armed once per stay in the reset wait state
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			armed_reg <= 1'b0;
		end
		else
		begin
			armed_reg <= (state_reg == swt_pkg::ST_RESET_WAIT) &&
				(state_next == swt_pkg::ST_RESET_WAIT);
		end
	end

	// Write header capture and buffer fill count
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cryptoWr_reg <= 1'b0;
			baseAddr_reg <= 8'h00;
			bufCount_reg <= 5'h00;
		end
		else if ((state_reg == swt_pkg::ST_IDLE) && wrCmd && !tamperNow)
		begin
			cryptoWr_reg <= cryptoMode;
			baseAddr_reg <= wrAddr;
			bufCount_reg <= 5'h00;
		end
		else if (bufWrite)
		begin
			bufCount_reg <= bufCount_reg + 5'h01;
		end
	end

	// Bytes held in the buffer; extra bytes beyond a page are dropped
	assign bufWrite = (state_reg == swt_pkg::ST_COLLECT) && wrByte &&
		!tamperNow && (bufCount_reg < 5'(swt_pkg::BUF_DEPTH));
	assign bufBus.wrEn = bufWrite;
	assign bufBus.wrIdx = bufCount_reg[swt_pkg::BUF_IDX_W-1:0];
	assign bufBus.wrData = wrData;

	// Buffer is drained only in the program state
	assign bufRead = (state_reg == swt_pkg::ST_PROGRAM) &&
		(rdCount_reg != bufCount_reg) && !tamperNow;
	assign bufBus.rdEn = bufRead;
	assign bufBus.rdIdx = rdCount_reg[swt_pkg::BUF_IDX_W-1:0];

	// Read pointer; read data comes back one cycle later
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdCount_reg <= 5'h00;
			rdPend_reg <= 1'b0;
			pendIdx_reg <= 4'h0;
		end
		else
		begin
			rdPend_reg <= bufRead;
			pendIdx_reg <= rdCount_reg[swt_pkg::BUF_IDX_W-1:0];
			if (state_reg != swt_pkg::ST_PROGRAM)
			begin
				rdCount_reg <= 5'h00;
			end
			else if (bufRead)
			begin
				rdCount_reg <= rdCount_reg + 5'h01;
			end
		end
	end

	// Array strobes come only from the program state
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			memWrEn_reg <= 1'b0;
			memAddr_reg <= 8'h00;
			memData_reg <= 8'h00;
		end
		else
		begin
			memWrEn_reg <= rdPend_reg && !tamperNow;
			if (rdPend_reg)
			begin
				memAddr_reg <= pageAddr(baseAddr_reg, pendIdx_reg);
				memData_reg <= bufBus.rdData;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cryptoReset_reg <= 1'b0;
			writeDropped_reg <= 1'b0;
		end
		else
		begin
			cryptoReset_reg <= (state_reg == swt_pkg::ST_AWAIT_SUM) &&
				!tamperNow && !otherTraffic && sumCmd && !sumMatch;
			writeDropped_reg <= !tamperNow && (state_reg ==
				swt_pkg::ST_AWAIT_SUM || state_reg ==
				swt_pkg::ST_AWAIT_STOP) && (state_next ==
				swt_pkg::ST_IDLE);
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			secFlags_reg <= swt_pkg::FLAGS_INIT;
		end
		else if (tamperNow || state_reg == swt_pkg::ST_TAMPER ||
			state_reg == swt_pkg::ST_RESET_WAIT)
		begin
			secFlags_reg <= swt_pkg::FLAGS_INIT;
		end
		else
		begin
			secFlags_reg <= secFlags_reg | flagSet;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			addrAck_reg <= 1'b0;
		end
		else
		begin
			addrAck_reg <= addrByte && !tamperNow && acceptsBus(state_reg);
		end
	end

	// Status levels; busy covers buffer drain and the timed cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			writeBusy_reg <= 1'b0;
			tamperFlag_reg <= 1'b0;
			deviceReady_reg <= 1'b0;
		end
		else
		begin
			writeBusy_reg <= (state_next == swt_pkg::ST_PROGRAM) ||
				(state_next == swt_pkg::ST_WRITE_CYCLE);
			tamperFlag_reg <= tamperNow;
			deviceReady_reg <= acceptsBus(state_next) ||
				(state_next == swt_pkg::ST_PROGRAM) ||
				(state_next == swt_pkg::ST_WRITE_CYCLE);
		end
	end

	swt_buffer_mem swt_buffer_mem_i
	(
		.clk  (clk),
		.nrst (nrst),
		.port (bufBus.mem)
	);

	swt_delay_timer swt_delay_timer_i
	(
		.clk     (clk),
		.nrst    (nrst),
		.load    (timerLoad),
		.loadVal (timerVal),
		.expired (timerDone)
	);

	assign addrAck = addrAck_reg;
	assign writeBusy = writeBusy_reg;
	assign memWrEn = memWrEn_reg;
	assign memAddr = memAddr_reg;
	assign memData = memData_reg;
	assign cryptoReset = cryptoReset_reg;
	assign writeDropped = writeDropped_reg;
	assign secFlags = secFlags_reg;
	assign tamperFlag = tamperFlag_reg;
	assign deviceReady = deviceReady_reg;

endmodule

// ==== logic/swt_buf_if.sv ====
// Carrier between the sequencer and its write buffer memory
`timescale 1ns/1ps
interface swt_buf_if;
	logic                           wrEn;
	logic [swt_pkg::BUF_IDX_W-1:0] wrIdx;
	logic [swt_pkg::DATA_W-1:0]    wrData;
	logic                           rdEn;
	logic [swt_pkg::BUF_IDX_W-1:0] rdIdx;
	logic [swt_pkg::DATA_W-1:0]    rdData;

	modport owner
	(
		output wrEn, wrIdx, wrData, rdEn, rdIdx,
		input  rdData
	);

	modport mem
	(
		input  wrEn, wrIdx, wrData, rdEn, rdIdx,
		output rdData
	);
endinterface

// ==== logic/swt_buffer_mem.sv ====
// Write buffer that holds one page of pending user zone data
`timescale 1ns/1ps
module swt_buffer_mem
(
	input  wire logic clk,  // System clock
	input  wire logic nrst, // Asynchronous reset, active low
	swt_buf_if.mem    port  // Buffer access
);

	logic [swt_pkg::DATA_W-1:0] store [swt_pkg::BUF_DEPTH];
	logic [swt_pkg::DATA_W-1:0] rdData_reg;

	// Storage carries no reset; stale bytes are never read past the count
	always_ff @(posedge clk)
	begin
		if (port.wrEn)
		begin
			store[port.wrIdx] <= port.wrData;
		end
	end

	// Registered read port
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdData_reg <= 8'h00;
		end
		else if (port.rdEn)
		begin
			rdData_reg <= store[port.rdIdx];
		end
	end

	assign port.rdData = rdData_reg;

endmodule

// ==== logic/swt_delay_timer.sv ====
// Down counter shared by the reset delay and the internal write cycle
`timescale 1ns/1ps
module swt_delay_timer
(
	input  wire logic                         clk,     // System clock
	input  wire logic                         nrst,    // Async reset, low
	input  wire logic                         load,    // Start a new delay
	input  wire logic [swt_pkg::TIMER_W-1:0] loadVal, // Delay in cycles
	output logic                              expired  // Count at zero
);

	logic [swt_pkg::TIMER_W-1:0] count_reg;

	// Load wins over counting so a restart is never lost
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			count_reg <= 20'h0_0000;
		end
		else if (load)
		begin
			count_reg <= loadVal;
		end
		else if (count_reg != 20'h0_0000)
		begin
			count_reg <= count_reg - 20'h0_0001;
		end
	end

	assign expired = (count_reg == 20'h0_0000) && !load;

endmodule

// ==== logic/swt_pkg.sv ====
// Shared constants and types for the secure write and tamper control block
package swt_pkg;

	// Clock rate and derived timing
	localparam int CLK_MHZ         = 200;
	localparam int WRITE_CYCLE_MS  = 5;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
	localparam int POR_DELAY_US    = 100;
	localparam int POR_DELAY_CYC   = POR_DELAY_US * CLK_MHZ;

	// Delay timer width, wide enough for the write cycle count
	localparam int TIMER_W = 20;
	localparam logic [TIMER_W-1:0] WRITE_CYCLE_LD = TIMER_W'(WRITE_CYCLE_CYC);
	localparam logic [TIMER_W-1:0] POR_DELAY_LD   = TIMER_W'(POR_DELAY_CYC);

	// Write buffer geometry
	localparam int BUF_DEPTH = 16;
	localparam int BUF_IDX_W = 4;
	localparam int BUF_CNT_W = 5;
	localparam int DATA_W    = 8;
	localparam int ADDR_W    = 8;

	// Checksum width
	localparam int SUM_W = 16;

	// Security flags and their positions
	localparam int FLAG_W    = 8;
	localparam int FLAG_AUTH = 0;
	localparam int FLAG_ENC  = 1;
	localparam logic [FLAG_W-1:0] FLAGS_INIT = 8'h00;

	// Control sequencer states
	typedef enum logic [2:0]
	{
		ST_TAMPER,
		ST_RESET_WAIT,
		ST_IDLE,
		ST_COLLECT,
		ST_AWAIT_SUM,
		ST_AWAIT_STOP,
		ST_PROGRAM,
		ST_WRITE_CYCLE
	} swt_state_type;

endpackage

// ==== verification/swt_host_model.sv ====
// Host controller model issuing decoded bus events to the block
`timescale 1ns/1ps
module swt_host_model
(
	input  wire logic                        clk,         // System clock
	output logic                             addrByte,    // Address event
	output logic                             wrCmd,       // Write header
	output logic [swt_pkg::ADDR_W-1:0]      wrAddr,      // Start address
	output logic                             wrByte,      // Data event
	output logic [swt_pkg::DATA_W-1:0]      wrData,      // Data byte
	output logic                             stopCond,    // Stop event
	output logic                             sumCmd,      // Checksum event
	output logic [swt_pkg::SUM_W-1:0]       sumWord,     // Host checksum
	output logic                             otherTraffic // Stray command
);
	logic [5:0] evt; // One bit per event kind

	assign {otherTraffic, sumCmd, stopCond, wrByte, wrCmd, addrByte} = evt;

	initial
	begin
		evt = '0;
		wrAddr = '0;
		wrData = '0;
		sumWord = '0;
	end

	// One-cycle event; data lines toggle once released, never hold
	task automatic ev(input int k, input logic [15:0] v);
		@(posedge clk);
		evt[k] <= 1'b1;
		wrAddr <= v[7:0];
		wrData <= v[7:0];
		sumWord <= v;
		@(posedge clk);
		evt <= '0;
		wrAddr <= ~v[7:0];
		wrData <= ~v[7:0];
		sumWord <= ~v;
	endtask

	// Full write; stray puts other traffic before the checksum
	task automatic writeSeq(input logic [7:0] a, input int n,
		input logic [7:0] d0, input logic crypto,
		input logic [15:0] s, input logic stray);
		ev(1, {8'h00, a});
		for (int i = 0; i < n; i++)
			ev(2, {8'h00, d0 + 8'(i)});
		ev(3, 16'h0000);
		if (crypto)
		begin
			if (stray)
				ev(5, 16'h0000);
			ev(4, s);
			ev(3, 16'h0000);
		end
	endtask
endmodule

// ==== verification/swt_props.sv ====
// Port level checks for the secure write and tamper control block
`timescale 1ns/1ps
module swt_props
#(
	parameter logic [swt_pkg::TIMER_W-1:0] WRITE_CYCLE_CYC =
		20'h0_0014,                                // Write cycle
	parameter logic [swt_pkg::TIMER_W-1:0] POR_DELAY_CYC   =
		20'h0_000A                                 // Reset delay
)
(
	input wire logic                        clk,          // System clock
	input wire logic                        nrst,         // Async reset, low
	input wire logic                        vccFault,     // Supply sensor
	input wire logic                        clkFault,     // Clock sensor
	input wire logic                        lightFault,   // Light sensor
	input wire logic                        addrByte,     // Address event
	input wire logic                        addrAck,      // Address acked
	input wire logic                        writeBusy,    // Write cycle
	input wire logic                        memWrEn,      // Array strobe
	input wire logic                        cryptoReset,  // Engine reset
	input wire logic                        writeDropped, // Write discarded
	input wire logic [swt_pkg::FLAG_W-1:0] secFlags,     // Security flags
	input wire logic                        tamperFlag,   // Tamper present
	input wire logic                        deviceReady   // Device operable
);
	logic [swt_pkg::TIMER_W-1:0] lowCnt;   // Quiet cycles while not ready
	logic [swt_pkg::TIMER_W-1:0] busyCnt;  // Cycles of current write
	logic                        anyFault; // Any sensor tripped

	assign anyFault = vccFault | clkFault | lightFault;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// Delay counter restarts on every fault so the bound is per event
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			lowCnt <= '0;
		else if (deviceReady || anyFault)
			lowCnt <= '0;
		else
			lowCnt <= lowCnt + 1'b1;

	// Length of the current busy stretch
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			busyCnt <= '0;
		else if (writeBusy)
			busyCnt <= busyCnt + 1'b1;
		else
			busyCnt <= '0;

	// Steps of acknowledge and tamper behaviour
	sequence s_ackReady;
		addrByte && deviceReady && !writeBusy && !anyFault;
	endsequence
	sequence s_faultHeld;
		tamperFlag[*2];
	endsequence

	a_ack_when_ready: assert property
		(s_ackReady |=> addrAck)
		else $error("address byte not acknowledged when idle");
	a_no_ack_busy: assert property
		(addrByte && writeBusy |=> !addrAck)
		else $error("address acknowledged during write cycle");
	a_volt_clk_tamper: assert property
		(vccFault || clkFault |=> tamperFlag)
		else $error("supply or clock fault not flagged");
	a_light_tamper: assert property
		(lightFault |=> tamperFlag)
		else $error("light fault not flagged");
	a_tamper_quiet: assert property
		(s_faultHeld |-> !deviceReady && !addrAck && !memWrEn)
		else $error("activity while tamper present");
	a_flags_initial: assert property
		((!deviceReady)[*3] |-> secFlags == swt_pkg::FLAGS_INIT)
		else $error("flags not at initial value during reset delay");
	a_delay_min: assert property
		($rose(deviceReady) |-> lowCnt >= POR_DELAY_CYC)
		else $error("device ready before reset delay ran out");
	a_delay_max: assert property
		(lowCnt <= POR_DELAY_CYC + 8)
		else $error("device not ready after reset delay");
	a_busy_min: assert property
		($fell(writeBusy) && !tamperFlag |-> busyCnt >= WRITE_CYCLE_CYC)
		else $error("write cycle ended early");
	a_busy_max: assert property
		(busyCnt <= WRITE_CYCLE_CYC + 24)
		else $error("write cycle too long");
	a_strobe_busy: assert property
		(memWrEn |-> writeBusy)
		else $error("array write outside write cycle");
	a_drop_pair: assert property
		(cryptoReset |-> writeDropped)
		else $error("engine reset without discarding the write");
endmodule

// ==== verification/test_secure_write_tamper_control.sv ====
// Self-checking bench for the secure write and tamper control block
`timescale 1ns/1ps
module test_secure_write_tamper_control;
	localparam logic [swt_pkg::TIMER_W-1:0] WCYC = 20'h0_0014; // Short write
	localparam logic [swt_pkg::TIMER_W-1:0] PCYC = 20'h0_000A; // Short delay
	localparam logic [swt_pkg::SUM_W-1:0]   SUM  = 16'hA5C3; // Engine sum

	logic clk, nrst, vccFault, clkFault, lightFault;
	logic addrByte, wrCmd, wrByte, stopCond, sumCmd, otherTraffic;
	logic addrAck, writeBusy, memWrEn, cryptoReset, writeDropped;
	logic tamperFlag, deviceReady;
	logic [7:0]  wrAddr, wrData, memAddr, memData, flagSet, secFlags;
	logic [15:0] sumWord, expSum;
	logic [7:0]  mem [0:255] = '{default: 8'h00};
	int          fails, total_checks, ackCnt, dropCnt, crstCnt, wrCnt;

	secure_write_tamper_control #(.WRITE_CYCLE_CYC(WCYC),
		.POR_DELAY_CYC(PCYC)) secure_write_tamper_control_i (.clk, .nrst,
		.vccFault, .clkFault, .lightFault, .addrByte, .wrCmd, .wrAddr,
		.wrByte, .wrData, .stopCond, .sumCmd, .sumWord, .expSum,
		.otherTraffic, .flagSet, .addrAck, .writeBusy, .memWrEn, .memAddr,
		.memData, .cryptoReset, .writeDropped, .secFlags, .tamperFlag,
		.deviceReady);
	swt_host_model swt_host_model_i (.clk, .addrByte, .wrCmd, .wrAddr,
		.wrByte, .wrData, .stopCond, .sumCmd, .sumWord, .otherTraffic);

	initial
		clk = 1'b0;
	always
		#2.5 clk = ~clk;

	// Array image and pulse tallies, taken mid-cycle once outputs settle
	always @(negedge clk)
	begin
		if (memWrEn === 1'b1)
		begin
			mem[memAddr] = memData;
			wrCnt++;
		end
		ackCnt += int'(addrAck === 1'b1);
		dropCnt += int'(writeDropped === 1'b1);
		crstCnt += int'(cryptoReset === 1'b1);
	end

	task automatic chk(input string what, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Bounded wait; the count must not undercut the delay
	task automatic waitReady;
		int n;
		n = 0;
		while (deviceReady !== 1'b1 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		#1;
		chk("deviceReady", 8'h01, 8'(deviceReady));
		chk("delay length", 8'h01, 8'(n >= int'(PCYC)));
	endtask

	task automatic waitIdle;
		int n;
		n = 0;
		repeat (2) @(posedge clk);
		while (writeBusy !== 1'b0 && n < 200)
		begin
			@(posedge clk);
			n++;
		end
		#1;
		chk("writeBusy", 8'h00, 8'(writeBusy));
	endtask

	// Address byte, then count acknowledges
	task automatic probe(input logic e);
		int c;
		c = ackCnt;
		swt_host_model_i.ev(0, 16'h0000);
		repeat (2) @(posedge clk);
		#1;
		chk("addrAck", 8'(e), 8'(ackCnt - c));
	endtask

	// Plain page write wrapping inside its page, polled while busy
	task automatic t_plain;
		int c;
		c = wrCnt;
		swt_host_model_i.writeSeq(8'h1E, 3, 8'h40, 1'b0, SUM, 1'b0);
		probe(1'b0);
		waitIdle;
		chk("bytes written", 8'h03, 8'(wrCnt - c));
		chk("mem 1E", 8'h40, mem[8'h1E]);
		chk("mem 10", 8'h42, mem[8'h10]);
		probe(1'b1);
		// Empty write returns to idle without a write cycle
		c = wrCnt;
		swt_host_model_i.writeSeq(8'hC0, 0, 8'h00, 1'b0, SUM, 1'b0);
		#1;
		chk("empty busy", 8'h00, 8'(writeBusy));
		probe(1'b1);
		chk("empty writes", 8'h00, 8'(wrCnt - c));
	endtask

	// Secured writes: good sum, bad sum, stray traffic
	task automatic t_crypto(input int fb);
		int c, d, r;
		@(posedge clk);
		flagSet <= 8'(1 << fb);
		@(posedge clk);
		flagSet <= 8'h00;
		repeat (2) @(posedge clk);
		#1;
		chk("mode flag", 8'h01, 8'(secFlags[fb]));
		c = wrCnt;
		swt_host_model_i.writeSeq(8'h80, 2, 8'h50 + 8'(fb), 1'b1, SUM, 1'b0);
		waitIdle;
		chk("good sum writes", 8'h02, 8'(wrCnt - c));
		chk("mem 81", 8'h51 + 8'(fb), mem[8'h81]);
		c = wrCnt;
		d = dropCnt;
		r = crstCnt;
		swt_host_model_i.writeSeq(8'h90, 2, 8'h11, 1'b1, ~SUM, 1'b0);
		repeat (4) @(posedge clk);
		#1;
		chk("bad sum writes", 8'h00, 8'(wrCnt - c));
		chk("engine reset", 8'h01, 8'(crstCnt - r));
		chk("bad sum drop", 8'h01, 8'(dropCnt - d));
		c = wrCnt;
		d = dropCnt;
		swt_host_model_i.writeSeq(8'hA0, 2, 8'h22, 1'b1, SUM, 1'b1);
		repeat (WCYC + 8) @(posedge clk);
		#1;
		chk("stray writes", 8'h00, 8'(wrCnt - c));
		chk("stray drop", 8'h01, 8'(dropCnt - d));
		chk("mem A0", 8'h00, mem[8'hA0]);
		// Stray traffic after a good sum, before the closing stop
		c = wrCnt;
		d = dropCnt;
		swt_host_model_i.ev(1, 16'h00B0);
		swt_host_model_i.ev(2, 16'h0033);
		swt_host_model_i.ev(3, 16'h0000);
		swt_host_model_i.ev(4, SUM);
		swt_host_model_i.ev(5, 16'h0000);
		swt_host_model_i.ev(3, 16'h0000);
		repeat (8) @(posedge clk);
		#1;
		chk("late stray writes", 8'h00, 8'(wrCnt - c));
		chk("late stray drop", 8'h01, 8'(dropCnt - d));
		chk("mem B0", 8'h00, mem[8'hB0]);
	endtask

	// Each sensor in turn shuts the device down, then the delay reruns
	task automatic t_tamper;
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			{lightFault, clkFault, vccFault} <= 3'(1 << k);
			repeat (4) @(posedge clk);
			#1;
			chk("tamperFlag", 8'h01, 8'(tamperFlag));
			chk("ready in tamper", 8'h00, 8'(deviceReady));
			probe(1'b0);
			chk("flags cleared", swt_pkg::FLAGS_INIT, secFlags);
			@(posedge clk);
			{lightFault, clkFault, vccFault} <= 3'b000;
			waitReady;
		end
	endtask

	// Reset in mid-run clears the flags and reruns the delay
	task automatic t_reset;
		@(posedge clk);
		flagSet <= 8'h01;
		@(posedge clk);
		flagSet <= 8'h00;
		#1;
		chk("flag before reset", 8'h01, 8'(secFlags[0]));
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("ready in reset", 8'h00, 8'(deviceReady));
		@(posedge clk);
		nrst <= 1'b1;
		waitReady;
		chk("flags after rerun", swt_pkg::FLAGS_INIT, secFlags);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		test_done;
	end

	initial
	begin
		nrst = 1'b0;
		{vccFault, clkFault, lightFault} = 3'b000;
		flagSet = 8'h00;
		expSum = SUM;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		waitReady;
		chk("flags after reset", swt_pkg::FLAGS_INIT, secFlags);
		t_plain;
		t_crypto(swt_pkg::FLAG_AUTH);
		t_tamper;
		t_crypto(swt_pkg::FLAG_ENC);
		t_reset;
		test_done;
	end
endmodule

bind secure_write_tamper_control swt_props #(.WRITE_CYCLE_CYC(WRITE_CYCLE_CYC),
	.POR_DELAY_CYC(POR_DELAY_CYC)) swt_props_i (.clk, .nrst, .vccFault,
	.clkFault, .lightFault, .addrByte, .addrAck, .writeBusy, .memWrEn,
	.cryptoReset, .writeDropped, .secFlags, .tamperFlag, .deviceReady);
